// ---- hw/uart_modem_status_flow_ctrl.sv ----
// Modem status, scratch byte and automatic CTS/RTS flow control of a UART
//
// How it works
// - Reading modem status clears all change flags
// - Status bit 7 is inverted CD, or OP2
// - Status bit 6 is inverted RI, or OP1
// - Status bit 5 is inverted DSR, or DTR
// - Status bit 4 is inverted CTS, or RTS
// - CD, DSR, CTS changes set flags 3,1,0
// - Ring flag sets only on pin rising
// - Any change flag raises modem interrupt
// - Scratch byte holds last written value
// - Feature bits 0-3 pick single/dual char mode
// - Dual mode pairs resume and pause chars
// - Auto CTS and RTS off after reset
// - Auto CTS halts transmitter while CTS high
// - Auto RTS interrupts at programmed trigger
// - Auto RTS drives pin high at next level
// - RTS low again below next lower level
// - Without auto RTS, pin follows control bit outside loopback
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "uart_msfc_cfg.svh"

module uart_modem_status_flow_ctrl
#(
    parameter int FIFO_DEPTH = `RX_FIFO_DEPTH,
    parameter int FILL_W     = 6,
    parameter int TRIG_L0    = `RX_TRIG_L0,
    parameter int TRIG_L1    = `RX_TRIG_L1,
    parameter int TRIG_L2    = `RX_TRIG_L2,
    parameter int TRIG_L3    = `RX_TRIG_L3
)
(
    // Clock, reset, enable
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      clk_en_i,
    // Register port
    input  wire logic [`MSFC_ADDR_W-1:0]   addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    // Modem inputs, active low, asynchronous
    input  wire logic                      cd_n_i,
    input  wire logic                      ri_n_i,
    input  wire logic                      dsr_n_i,
    input  wire logic                      cts_n_i,
    // Modem outputs, active low
    output logic                           rts_n_o,
    output logic                           dtr_n_o,
    output logic                           op1_n_o,
    output logic                           op2_n_o,
    // Receive FIFO and transmitter side
    input  wire logic [FILL_W-1:0]         rx_fill_i,
    input  wire logic [1:0]                trig_sel_i,
    output logic                           tx_en_o,
    // Software flow control selection
    output logic [3:0]                     sw_flow_sel_o,
    output logic                           tx_dual_o,
    output logic                           rx_dual_o,
    output logic [15:0]                    resume_pair_o,
    output logic [15:0]                    pause_pair_o,
    // Interrupt
    output logic                           irq_o
);

    initial
    begin
        if (FIFO_DEPTH >= (1 << FILL_W) || TRIG_L0 < 1 ||
            TRIG_L0 >= TRIG_L1 || TRIG_L1 >= TRIG_L2 ||
            TRIG_L2 >= TRIG_L3 || TRIG_L3 > FIFO_DEPTH)
            $error("uart_modem_status_flow_ctrl: bad FIFO parameters");
    end

    // Trigger level by index; index 4 stands for a full FIFO
    function automatic logic [FILL_W-1:0] trig_level(input logic [2:0] idx);
        case (idx)
            3'h0:    trig_level = FILL_W'(TRIG_L0);
            3'h1:    trig_level = FILL_W'(TRIG_L1);
            3'h2:    trig_level = FILL_W'(TRIG_L2);
            3'h3:    trig_level = FILL_W'(TRIG_L3);
            default: trig_level = FILL_W'(FIFO_DEPTH);
        endcase
    endfunction

    function automatic logic reg_hit(input logic                  strobe,
                                     input logic [`MSFC_ADDR_W-1:0] ofs);
        reg_hit = strobe && (addr_i == ofs);
    endfunction

    localparam uart_msfc_pkg::state_t STATE_RST = '{
        sync1:     4'hF,
        sync2:     4'hF,
        stat_prev: 4'h0,
        delta:     4'h0,
        modem_control_reg:       `MCR_RST,
        scratch:   `BYTE_RST,
        enhanced_feature_control:       `EFR_RST,
        resume1:   `BYTE_RST,
        resume2:   `BYTE_RST,
        pause1:    `BYTE_RST,
        pause2:    `BYTE_RST,
        int_stat:  `INT_RST,
        int_en:    `INT_RST,
        trig_prev: 1'b0,
        rts_st:    uart_msfc_pkg::RTS_OPEN,
        rdata:     8'h00,
        rts_n:     1'b1,
        dtr_n:     1'b1,
        op1_n:     1'b1,
        op2_n:     1'b1,
        tx_en:     1'b1,
        irq:       1'b0
    };

    uart_msfc_pkg::state_t s_r;
    uart_msfc_pkg::state_t s_nxt;

    logic [3:0]        stat_now;
    logic [3:0]        edge_vec;
    logic [7:0]        msr_val;
    logic              loop_on;
    logic              auto_cts;
    logic              auto_rts;
    logic              msr_rd;
    logic              at_trig;
    logic [FILL_W-1:0] lvl_next;
    logic [FILL_W-1:0] lvl_low;

    assign loop_on  = s_r.modem_control_reg[`MCR_LOOP];
    assign auto_cts = s_r.enhanced_feature_control[`EFR_AUTO_CTS];
    assign auto_rts = s_r.enhanced_feature_control[`EFR_AUTO_RTS];
    assign msr_rd   = reg_hit(rd_i, `MSFC_OFS_MODEM_STAT);

    // Upper status nibble: {CD, RI, DSR, CTS}
    always_comb
    begin
        if (loop_on)
            stat_now = {s_r.modem_control_reg[`MCR_OP2], s_r.modem_control_reg[`MCR_OP1],
                        s_r.modem_control_reg[`MCR_DTR], s_r.modem_control_reg[`MCR_RTS]};
        else
            stat_now = ~s_r.sync2;
    end

    // Change detection works on the reported state, so loopback
    // exercises the flags exactly as the pins would.
    always_comb
    begin
        edge_vec[3] = stat_now[3] ^ s_r.stat_prev[3];
        edge_vec[2] = s_r.stat_prev[2] & ~stat_now[2];
        edge_vec[1] = stat_now[1] ^ s_r.stat_prev[1];
        edge_vec[0] = stat_now[0] ^ s_r.stat_prev[0];
    end

    assign msr_val = {stat_now, s_r.delta};

    // RTS release below the level under the programmed one
    assign at_trig  = rx_fill_i >= trig_level({1'b0, trig_sel_i});
    assign lvl_next = trig_level({1'b0, trig_sel_i} + 3'h1);
    assign lvl_low  = (trig_sel_i == 2'h0) ? trig_level(3'h0)
                                           : trig_level({1'b0, trig_sel_i}
                                                        - 3'h1);

    always_comb
    begin
        s_nxt = s_r;
        // Only sync2 is read by logic; sync1 feeds sync2 alone
        s_nxt.sync1     = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
        s_nxt.sync2     = s_r.sync1;
        s_nxt.stat_prev = stat_now;

        // Set wins over the read clear
        s_nxt.delta = (msr_rd ? 4'h0 : s_r.delta) | edge_vec;

        if (reg_hit(wr_i, `MSFC_OFS_MODEM_CTRL))
            s_nxt.modem_control_reg = wdata_i[4:0];
        if (reg_hit(wr_i, `MSFC_OFS_SCRATCH))
            s_nxt.scratch = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_ENH_FEAT))
            s_nxt.enhanced_feature_control = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_RESUME1))
            s_nxt.resume1 = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_RESUME2))
            s_nxt.resume2 = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_PAUSE1))
            s_nxt.pause1 = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_PAUSE2))
            s_nxt.pause2 = wdata_i;
        if (reg_hit(wr_i, `MSFC_OFS_INT_EN))
            s_nxt.int_en = wdata_i[1:0];

        // Interrupt status: clear first, then events so they win
        if (reg_hit(wr_i, `MSFC_OFS_INT_CLR))
            s_nxt.int_stat = s_r.int_stat & ~wdata_i[1:0];
        if (msr_rd)
            s_nxt.int_stat[`INT_MODEM] = 1'b0;
        if (|s_nxt.delta)
            s_nxt.int_stat[`INT_MODEM] = 1'b1;
        s_nxt.trig_prev = at_trig;
        if (auto_rts && at_trig && !s_r.trig_prev)
            s_nxt.int_stat[`INT_RX_TRIG] = 1'b1;

        // Auto RTS hysteresis
        case (s_r.rts_st)
            uart_msfc_pkg::RTS_OPEN:
            begin
                if (auto_rts && rx_fill_i >= lvl_next)
                    s_nxt.rts_st = uart_msfc_pkg::RTS_HELD;
            end
            uart_msfc_pkg::RTS_HELD:
            begin
                if (!auto_rts || rx_fill_i < lvl_low)
                    s_nxt.rts_st = uart_msfc_pkg::RTS_OPEN;
            end
            default:
                s_nxt.rts_st = uart_msfc_pkg::RTS_OPEN;
        endcase

        // Pins go inactive in loopback so the modem sees no stray levels
        if (loop_on)
        begin
            s_nxt.rts_n = 1'b1;
            s_nxt.dtr_n = 1'b1;
            s_nxt.op1_n = 1'b1;
            s_nxt.op2_n = 1'b1;
        end
        else
        begin
            if (s_nxt.enhanced_feature_control[`EFR_AUTO_RTS])
                s_nxt.rts_n = (s_nxt.rts_st == uart_msfc_pkg::RTS_HELD);
            else
                s_nxt.rts_n = ~s_nxt.modem_control_reg[`MCR_RTS];
            s_nxt.dtr_n = ~s_nxt.modem_control_reg[`MCR_DTR];
            s_nxt.op1_n = ~s_nxt.modem_control_reg[`MCR_OP1];
            s_nxt.op2_n = ~s_nxt.modem_control_reg[`MCR_OP2];
        end

        // Transmitter stops while CTS pin is high; this relies on the
        // modem holding CTS high only to pause us
        s_nxt.tx_en = ~(s_nxt.enhanced_feature_control[`EFR_AUTO_CTS] &
                        s_r.sync2[0]);

        s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_en);

        // Read data appear in the cycle after the strobe only
        s_nxt.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `MSFC_OFS_MODEM_STAT: s_nxt.rdata = msr_val;
                `MSFC_OFS_MODEM_CTRL: s_nxt.rdata = {3'h0, s_r.modem_control_reg};
                `MSFC_OFS_SCRATCH:    s_nxt.rdata = s_r.scratch;
                `MSFC_OFS_ENH_FEAT:   s_nxt.rdata = s_r.enhanced_feature_control;
                `MSFC_OFS_RESUME1:    s_nxt.rdata = s_r.resume1;
                `MSFC_OFS_RESUME2:    s_nxt.rdata = s_r.resume2;
                `MSFC_OFS_PAUSE1:     s_nxt.rdata = s_r.pause1;
                `MSFC_OFS_PAUSE2:     s_nxt.rdata = s_r.pause2;
                `MSFC_OFS_INT_STAT:   s_nxt.rdata = {6'h00, s_r.int_stat};
                `MSFC_OFS_INT_EN:     s_nxt.rdata = {6'h00, s_r.int_en};
                default:              s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            s_r <= STATE_RST;
        else if (clk_en_i)
            s_r <= s_nxt;
    end

    assign rdata_o = s_r.rdata;
    assign rts_n_o = s_r.rts_n;
    assign dtr_n_o = s_r.dtr_n;
    assign op1_n_o = s_r.op1_n;
    assign op2_n_o = s_r.op2_n;
    assign tx_en_o = s_r.tx_en;
    assign irq_o   = s_r.irq;

    // Software flow control selection from the feature register, character pairs from the resume and pause registers
    assign sw_flow_sel_o = s_r.enhanced_feature_control[3:0];
    assign tx_dual_o     = s_r.enhanced_feature_control[3] & s_r.enhanced_feature_control[2];
    assign rx_dual_o     = s_r.enhanced_feature_control[1] & s_r.enhanced_feature_control[0];
    assign resume_pair_o = {s_r.resume1, s_r.resume2};
    assign pause_pair_o  = {s_r.pause1, s_r.pause2};

    // Checks

    default clocking chk_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    read_clears_flags_a: assert property (
        clk_en_i && msr_rd && edge_vec == 4'h0 |=> s_r.delta == 4'h0)
        else $error("change flags not cleared by status read");

    loop_status_a: assert property (
        clk_en_i && rd_i && addr_i == `MSFC_OFS_MODEM_STAT && loop_on
        |=> rdata_o[7:4] == {$past(s_r.modem_control_reg[3]), $past(s_r.modem_control_reg[2]),
                             $past(s_r.modem_control_reg[0]), $past(s_r.modem_control_reg[1])})
        else $error("loopback status does not follow control bits");

    cts_change_a: assert property (
        clk_en_i && edge_vec[0] |=> s_r.delta[0])
        else $error("CTS change flag missed");

    ri_rise_only_a: assert property (
        clk_en_i && !loop_on && s_r.stat_prev[2] == 1'b0 &&
        stat_now[2] == 1'b1 && !s_r.delta[2] && msr_rd |=> !s_r.delta[2])
        else $error("ring flag set on falling pin");

    modem_irq_a: assert property (
        clk_en_i && |edge_vec && s_r.int_en[`INT_MODEM] &&
        !reg_hit(wr_i, `MSFC_OFS_INT_EN) |=> irq_o)
        else $error("modem interrupt not raised");

    scratch_hold_a: assert property (
        clk_en_i && reg_hit(wr_i, `MSFC_OFS_SCRATCH)
        |=> s_r.scratch == $past(wdata_i))
        else $error("scratch byte lost write");

    // The default disable would mask this one, since it looks at reset
    reset_flow_a: assert property (@(posedge core_clk_i)
        disable iff (1'b0)
        !resetn_i |=> s_r.enhanced_feature_control[7:6] == 2'b00 && tx_en_o)
        else $error("auto flow control active after reset");

    cts_halt_a: assert property (
        clk_en_i && auto_cts && s_r.sync2[0] &&
        !reg_hit(wr_i, `MSFC_OFS_ENH_FEAT) |=> !tx_en_o)
        else $error("transmitter not halted by CTS");

    rts_raise_a: assert property (
        clk_en_i && auto_rts && !loop_on && rx_fill_i >= lvl_next &&
        !reg_hit(wr_i, `MSFC_OFS_ENH_FEAT) &&
        !reg_hit(wr_i, `MSFC_OFS_MODEM_CTRL) |=> ##1 rts_n_o || !clk_en_i)
        else $error("RTS not raised at next level");

    rts_manual_a: assert property (
        clk_en_i && !s_nxt.enhanced_feature_control[6] && !s_nxt.modem_control_reg[4]
        |=> rts_n_o == ~s_r.modem_control_reg[`MCR_RTS])
        else $error("RTS pin ignores control bit");

    cov_cd_change_c:  cover property (clk_en_i && edge_vec[3] ##1 irq_o);
    cov_rts_cycle_c:  cover property (
        s_r.rts_st == uart_msfc_pkg::RTS_HELD ##[1:200]
        s_r.rts_st == uart_msfc_pkg::RTS_OPEN);
    cov_cts_pause_c:  cover property (tx_en_o ##1 !tx_en_o ##[1:50] tx_en_o);

endmodule

// ---- hw/uart_msfc_cfg.svh ----
// Offsets, field positions, reset values and trigger levels of the block
`ifndef UART_MSFC_CFG_SVH
`define UART_MSFC_CFG_SVH

// Register indexes on the 4-bit register port
`define MSFC_ADDR_W          4
`define MSFC_OFS_MODEM_STAT  4'h0
`define MSFC_OFS_MODEM_CTRL  4'h1
`define MSFC_OFS_SCRATCH     4'h2
`define MSFC_OFS_ENH_FEAT    4'h3
`define MSFC_OFS_RESUME1     4'h4
`define MSFC_OFS_RESUME2     4'h5
`define MSFC_OFS_PAUSE1      4'h6
`define MSFC_OFS_PAUSE2      4'h7
`define MSFC_OFS_INT_STAT    4'h8
`define MSFC_OFS_INT_EN      4'h9
`define MSFC_OFS_INT_CLR     4'hA

// Modem control fields
`define MCR_DTR              0
`define MCR_RTS              1
`define MCR_OP1              2
`define MCR_OP2              3
`define MCR_LOOP             4

// Enhanced feature fields
`define EFR_AUTO_RTS         6
`define EFR_AUTO_CTS         7

// Interrupt status fields
`define INT_MODEM            0
`define INT_RX_TRIG          1

// Reset values
`define MCR_RST              5'h00
`define EFR_RST              8'h00
`define BYTE_RST             8'h00
`define INT_RST              2'h0

// Receive FIFO depth and trigger levels in bytes
`define RX_FIFO_DEPTH        32
`define RX_TRIG_L0           8
`define RX_TRIG_L1           16
`define RX_TRIG_L2           24
`define RX_TRIG_L3           28

`endif

// ---- hw/uart_msfc_pkg.sv ----
// Types shared by the modem status and flow control block
package uart_msfc_pkg;

    typedef enum logic [0:0] {
        RTS_OPEN = 1'b0,
        RTS_HELD = 1'b1
    } rts_state_t;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] stat_prev;
        logic [3:0] delta;
        logic [4:0] modem_control_reg;
        logic [7:0] scratch;
        logic [7:0] enhanced_feature_control;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
        logic [1:0] int_stat;
        logic [1:0] int_en;
        logic       trig_prev;
        rts_state_t rts_st;
        logic [7:0] rdata;
        logic       rts_n;
        logic       dtr_n;
        logic       op1_n;
        logic       op2_n;
        logic       tx_en;
        logic       irq;
    } state_t;

endpackage

// ---- test/modem_model.sv ----
// Modem model that drives the four handshake inputs of the block
`timescale 1ns/10ps
module modem_model
(
    // Clock and commanded line levels
    input  wire logic       core_clk_i,
    input  wire logic [3:0] lvl_i,
    // Handshake lines towards the block, active low
    output logic            cd_n_o,
    output logic            ri_n_o,
    output logic            dsr_n_o,
    output logic            cts_n_o
);
    // Lines move just after an edge, as a real modem would be
    // asynchronous to us anyway; a high clear-to-send pauses the
    // block's transmitter and a low one lets it send
    always_ff @(posedge core_clk_i)
    begin
        {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= lvl_i;
    end
endmodule

// ---- test/uart_modem_status_flow_ctrl_tb_top.sv ----
// Self-checking testbench of the modem status and flow control block
`timescale 1ns/10ps
`include "uart_msfc_cfg.svh"
module uart_modem_status_flow_ctrl_tb_top;
    logic        core_clk_i = 1'b0;
    logic        resetn_i   = 1'b0;
    logic [3:0]  addr_i     = 4'h0;
    logic [7:0]  wdata_i    = 8'h00;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic [5:0]  rx_fill_i  = 6'h00;
    logic [1:0]  trig_sel_i = 2'h0;
    logic [3:0]  lvl        = 4'hF;
    logic        clk_en     = 1'b1;
    logic [7:0]  rdata_o;
    logic        cd_n, ri_n, dsr_n, cts_n;
    logic        rts_n_o, dtr_n_o, op1_n_o, op2_n_o, tx_en_o, irq_o;
    logic [3:0]  sw_flow_sel_o;
    logic        tx_dual_o, rx_dual_o;
    logic [15:0] resume_pair_o, pause_pair_o;
    int          failures   = 0;
    int          num_checks = 0;

    uart_modem_status_flow_ctrl i_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .cd_n_i(cd_n), .ri_n_i(ri_n),
        .dsr_n_i(dsr_n), .cts_n_i(cts_n), .rts_n_o(rts_n_o),
        .dtr_n_o(dtr_n_o), .op1_n_o(op1_n_o), .op2_n_o(op2_n_o),
        .rx_fill_i(rx_fill_i), .trig_sel_i(trig_sel_i),
        .tx_en_o(tx_en_o), .sw_flow_sel_o(sw_flow_sel_o),
        .tx_dual_o(tx_dual_o), .rx_dual_o(rx_dual_o),
        .resume_pair_o(resume_pair_o), .pause_pair_o(pause_pair_o),
        .irq_o(irq_o));

    modem_model i_modem (
        .core_clk_i(core_clk_i), .lvl_i(lvl), .cd_n_o(cd_n),
        .ri_n_o(ri_n), .dsr_n_o(dsr_n), .cts_n_o(cts_n));

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data are sampled in the one cycle where they stand
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic t_reset();
        logic [7:0] d;
        chk({rts_n_o, dtr_n_o, op1_n_o, op2_n_o, tx_en_o, irq_o}, 6'h3E);
        for (int a = 1; a < 4; a++)
        begin
            rd(a[3:0], d);
            chk(d, 8'h00);
        end
        rd(4'hF, d);
        chk(d, 8'h00);
    endtask

    task automatic t_scratch();
        logic [7:0] d;
        wr(`MSFC_OFS_SCRATCH, 8'hA5);
        rd(`MSFC_OFS_SCRATCH, d);
        chk(d, 8'hA5);
        wr(`MSFC_OFS_SCRATCH, 8'hFF);
        rd(`MSFC_OFS_SCRATCH, d);
        chk(d, 8'hFF);
        rd(`MSFC_OFS_MODEM_CTRL, d);
        chk({d, rts_n_o, dtr_n_o, tx_en_o}, 11'h007);
    endtask

    task automatic t_sw();
        logic [7:0] d;
        wr(`MSFC_OFS_ENH_FEAT, 8'h0F);
        wr(`MSFC_OFS_RESUME1, 8'h11);
        wr(`MSFC_OFS_RESUME2, 8'h13);
        wr(`MSFC_OFS_PAUSE1, 8'h19);
        wr(`MSFC_OFS_PAUSE2, 8'h93);
        cyc(2);
        chk({sw_flow_sel_o, tx_dual_o, rx_dual_o}, 6'h3F);
        chk(resume_pair_o, 16'h1113);
        chk(pause_pair_o, 16'h1993);
        wr(`MSFC_OFS_ENH_FEAT, 8'h06);
        cyc(2);
        chk({sw_flow_sel_o, tx_dual_o, rx_dual_o}, 6'h18);
        rd(`MSFC_OFS_ENH_FEAT, d);
        chk(d, 8'h06);
        wr(`MSFC_OFS_ENH_FEAT, 8'h00);
    endtask

    // Pin steps cover every change direction, the ring pin both ways
    task automatic t_modem();
        logic [3:0] pv [6] = '{4'hE, 4'hC, 4'h4, 4'h0, 4'h4, 4'hF};
        logic [7:0] ev [6] = '{8'h11, 8'h32, 8'hB8, 8'hF0, 8'hB4, 8'h0B};
        logic [7:0] d;
        wr(`MSFC_OFS_INT_EN, 8'h01);
        rd(`MSFC_OFS_MODEM_STAT, d);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk_i);
            lvl <= pv[i];
            cyc(5);
            chk(irq_o, ev[i][3:0] != 4'h0);
            rd(`MSFC_OFS_MODEM_STAT, d);
            chk(d, ev[i]);
            rd(`MSFC_OFS_MODEM_STAT, d);
            chk(d, {ev[i][7:4], 4'h0});
            chk(irq_o, 1'b0);
        end
    endtask

    task automatic t_loop();
        logic [7:0] d;
        for (int m = 0; m < 16; m++)
        begin
            wr(`MSFC_OFS_MODEM_CTRL, 8'h10 | m[7:0]);
            cyc(2);
            rd(`MSFC_OFS_MODEM_STAT, d);
            chk(d[7:4], {m[3], m[2], m[0], m[1]});
        end
        wr(`MSFC_OFS_MODEM_CTRL, 8'h00);
        cyc(2);
        rd(`MSFC_OFS_MODEM_STAT, d);
        wr(`MSFC_OFS_MODEM_CTRL, 8'h03);
        cyc(2);
        chk({rts_n_o, dtr_n_o, op1_n_o, op2_n_o}, 4'h3);
        wr(`MSFC_OFS_MODEM_CTRL, 8'h0C);
        cyc(2);
        chk({rts_n_o, dtr_n_o, op1_n_o, op2_n_o}, 4'hC);
        wr(`MSFC_OFS_MODEM_CTRL, 8'h00);
    endtask

    task automatic t_cts();
        logic [7:0] d;
        cyc(2);
        chk(tx_en_o, 1'b1);
        wr(`MSFC_OFS_ENH_FEAT, 8'h80);
        cyc(5);
        chk(tx_en_o, 1'b0);
        lvl <= 4'hE;
        cyc(5);
        chk(tx_en_o, 1'b1);
        lvl <= 4'hF;
        cyc(5);
        chk(tx_en_o, 1'b0);
        wr(`MSFC_OFS_ENH_FEAT, 8'h00);
        cyc(3);
        chk(tx_en_o, 1'b1);
        rd(`MSFC_OFS_MODEM_STAT, d);
    endtask

    // Programmed level 16: raise at 24, release only below 8
    task automatic t_rts();
        logic [7:0] d;
        trig_sel_i <= 2'h1;
        rx_fill_i  <= 6'd15;
        wr(`MSFC_OFS_INT_EN, 8'h02);
        wr(`MSFC_OFS_ENH_FEAT, 8'h40);
        cyc(3);
        chk({irq_o, rts_n_o}, 2'b00);
        rx_fill_i <= 6'd16;
        cyc(3);
        chk({irq_o, rts_n_o}, 2'b10);
        rd(`MSFC_OFS_INT_STAT, d);
        chk(d, 8'h02);
        rx_fill_i <= 6'd24;
        cyc(3);
        chk(rts_n_o, 1'b1);
        rx_fill_i <= 6'd8;
        cyc(3);
        chk(rts_n_o, 1'b1);
        rx_fill_i <= 6'd7;
        cyc(3);
        chk(rts_n_o, 1'b0);
        wr(`MSFC_OFS_INT_CLR, 8'h02);
        cyc(2);
        chk(irq_o, 1'b0);
        wr(`MSFC_OFS_ENH_FEAT, 8'h00);
        rx_fill_i <= 6'd30;
        cyc(3);
        chk(rts_n_o, 1'b1);
    endtask

    // With the enable low neither writes nor pin changes may land
    task automatic t_freeze();
        logic [7:0] d;
        @(posedge core_clk_i);
        clk_en <= 1'b0;
        wr(`MSFC_OFS_SCRATCH, 8'h5A);
        lvl <= 4'hE;
        cyc(5);
        chk(rdata_o, 8'h00);
        clk_en <= 1'b1;
        rd(`MSFC_OFS_SCRATCH, d);
        chk(d, 8'hFF);
        cyc(5);
        rd(`MSFC_OFS_MODEM_STAT, d);
        chk(d, 8'h11);
        lvl <= 4'hF;
        cyc(5);
        rd(`MSFC_OFS_MODEM_STAT, d);
        chk(d, 8'h01);
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        failures++;
        finish_test();
    end

    initial
    begin
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_scratch();
        t_sw();
        t_modem();
        t_loop();
        t_cts();
        t_rts();
        t_freeze();
        finish_test();
    end
endmodule
